// [mmr_pkg.sv]
// Constants for the physical-address router: register indices, field layouts, reset values.
// Assumes a register port of the core that moves whole 64-bit words by index.
//
// What this block does
// [R1] Attribute bit3 routes writes, bit4 reads
// [R2] Attribute bits 2-0 keep the memory type
// [R3] Fixed routing only while config bit 18
// [R4] Config bit 19 gates routing-bit access
// [R5] Software sets modify, programs, then enables
// [R6] Only listed type/routing combinations are legal
// [R7] Two I/O ranges, each base/mask pair
// [R8] Base bit3 routes writes, bit4 reads
// [R9] Base holds address bits 51 to 12
// [R10] Mask bit 11 marks pair valid
// [R11] Mask bits 51 to 12 define extent
// [R12] Hit when masked address equals masked base
// [R13] I/O range combinations follow same table
// [R14] Overlapping I/O ranges are implementation dependent
// [R15] Low limit splits space below 4 Gbyte
// [R16] High limit splits space above 4 Gbyte
// [R17] Limits use bits 51 to 23 only
// [R18] Config bits 20/21 enable limits, else I/O
// [R19] Limit regions combinations follow same table
package mmr_pkg;

  localparam int ADDR_W      = 52;
  localparam int FIX_REGS    = 11;
  localparam int FIX_FIELDS  = FIX_REGS * 8;
  localparam int IO_RANGES   = 2;

  // Register indices on the register port
  localparam logic [7:0] IDX_FIX0       = 8'h00;
  localparam logic [7:0] IDX_SYS_CONFIG = 8'h0B;
  localparam logic [7:0] IDX_IOBASE0    = 8'h0C;
  localparam logic [7:0] IDX_IOMASK0    = 8'h0D;
  localparam logic [7:0] IDX_IOBASE1    = 8'h0E;
  localparam logic [7:0] IDX_IOMASK1    = 8'h0F;
  localparam logic [7:0] IDX_LOWLIM     = 8'h10;
  localparam logic [7:0] IDX_HIGHLIM    = 8'h11;

  // Attribute and base-register field positions
  localparam int BIT_WRITE_TO_DRAM = 3;
  localparam int BIT_READ_FROM_DRAM = 4;
  localparam int TYPE_MSB = 2;

  // System configuration bits
  localparam int BIT_FIX_ROUTE_EN = 18;
  localparam int BIT_FIX_MOD_EN   = 19;
  localparam int BIT_LOW_LIM_EN   = 20;
  localparam int BIT_HIGH_LIM_EN  = 21;

  // I/O range and memory-limit fields
  localparam int BIT_RANGE_VALID = 11;
  localparam int RANGE_LSB       = 12;
  localparam int LIMIT_LSB       = 23;

  // Fixed-range address map
  localparam logic [19:0] FIX_16K_START = 20'h8_0000;
  localparam logic [19:0] FIX_4K_START  = 20'hC_0000;
  localparam logic [6:0]  FIX_16K_FIRST = 7'h08;
  localparam logic [6:0]  FIX_4K_FIRST  = 7'h18;
  localparam logic [51:0] FIX_TOP       = 52'h0_0000_0010_0000;
  localparam logic [51:0] FOUR_GIG      = 52'h0_0001_0000_0000;

  // Memory type codes
  localparam logic [2:0] MT_UC = 3'h0;
  localparam logic [2:0] MT_WC = 3'h1;
  localparam logic [2:0] MT_WT = 3'h4;
  localparam logic [2:0] MT_WP = 3'h5;
  localparam logic [2:0] MT_WB = 3'h6;

  // Reset values
  localparam logic [63:0] RST_WORD = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  RST_ATTR = 8'h00;

endpackage

// [mmr_combo_check.sv]
// Legality check of a routing pair against a memory type.
// Assumes purely combinational use by the router top.
`timescale 1ns/100ps
`default_nettype none
module mmr_combo_check (
  // Routing pair and type
  input  wire logic       readFromDram,
  input  wire logic       writeToDram,
  input  wire logic [2:0] memType,
  // Result
  output logic            comboLegal
);

  always_comb begin
    unique case ({readFromDram, writeToDram})
      2'b00: comboLegal = (memType == mmr_pkg::MT_UC) || (memType == mmr_pkg::MT_WC) ||
                          (memType == mmr_pkg::MT_WT) || (memType == mmr_pkg::MT_WP); // [R6]
      2'b01: comboLegal = (memType == mmr_pkg::MT_UC) || (memType == mmr_pkg::MT_WC); // [R6]
      2'b10: comboLegal = (memType == mmr_pkg::MT_UC) || (memType == mmr_pkg::MT_WP); // [R6]
      2'b11: comboLegal = (memType == mmr_pkg::MT_UC) || (memType == mmr_pkg::MT_WC) ||
                          (memType == mmr_pkg::MT_WT) || (memType == mmr_pkg::MT_WB); // [R6]
    endcase
  end

endmodule
`default_nettype wire

// [mmr_router.sv]
// Physical-address router: register set plus per-access memory/I-O decision.
// Assumes a register port of the core and one lookup request per cycle.
`timescale 1ns/100ps
`default_nettype none
module mmr_router (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regIdx,
  input  wire logic [63:0] regWrData,
  output logic [63:0]      regRdData,
  output logic             regRdValid,
  output logic             regBadIdx,
  // Lookup request
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [51:0] reqAddr,
  input  wire logic [2:0]  reqVarType,
  // Lookup answer
  output logic             rspValid,
  output logic             rspToDram,
  output logic [2:0]       rspMemType,
  output logic             rspComboBad
);

  // Register state
  logic [7:0]  fixAttr_ff [mmr_pkg::FIX_FIELDS];
  logic [3:0]  system_configuration_ff;
  logic [51:12] ioBase_ff [mmr_pkg::IO_RANGES];
  logic [1:0]  ioRoute_ff [mmr_pkg::IO_RANGES];
  logic [51:12] ioMask_ff [mmr_pkg::IO_RANGES];
  logic        ioValid_ff [mmr_pkg::IO_RANGES];
  logic [51:23] lowLim_ff;
  logic [51:23] highLim_ff;

  // Answer registers
  logic [63:0] regRdData_ff;
  logic        regRdValid_ff;
  logic        regBadIdx_ff;
  logic        rspValid_ff;
  logic        rspToDram_ff;
  logic [2:0]  rspMemType_ff;
  logic        rspComboBad_ff;

  // Lookup terms
  logic        fixRouteEn;
  logic        fixModEn;
  logic        lowLimEn;
  logic        highLimEn;
  logic        inFixed;
  logic [6:0]  fixSel;
  logic [7:0]  fixAttr;
  logic        ioHit;
  logic [1:0]  ioRoute;
  logic        nxt_toDram;
  logic        routeRd;
  logic        routeWr;
  logic [2:0]  nxt_memType;
  logic        checkCombo;
  logic        comboLegal;
  logic [63:0] nxt_rdData;
  logic        nxt_badIdx;

  // Field index of a fixed-range address below 1 Mbyte
  function automatic logic [6:0] fixIndex(input logic [19:0] a);
    if (a < mmr_pkg::FIX_16K_START) begin
      fixIndex = {4'h0, a[18:16]};
    end else if (a < mmr_pkg::FIX_4K_START) begin
      fixIndex = mmr_pkg::FIX_16K_FIRST + {3'h0, a[17:14]};
    end else begin
      fixIndex = mmr_pkg::FIX_4K_FIRST + {1'b0, a[17:12]};
    end
  endfunction

  // Masked compare of one I/O range
  function automatic logic rangeMatch(input logic [51:12] addr,
                                      input logic [51:12] base,
                                      input logic [51:12] mask);
    rangeMatch = ((addr & mask) == (base & mask)); // [R12]
  endfunction

  assign fixRouteEn = system_configuration_ff[0];
  assign fixModEn   = system_configuration_ff[1];
  assign lowLimEn   = system_configuration_ff[2];
  assign highLimEn  = system_configuration_ff[3];

  // System configuration enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      system_configuration_ff <= 4'h0;
    end else if (regWrEn && regIdx == mmr_pkg::IDX_SYS_CONFIG) begin
      system_configuration_ff <= regWrData[mmr_pkg::BIT_HIGH_LIM_EN:mmr_pkg::BIT_FIX_ROUTE_EN]; // [R18]
    end
  end

  // Fixed-range attributes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < mmr_pkg::FIX_FIELDS; i++) begin
        fixAttr_ff[i] <= mmr_pkg::RST_ATTR;
      end
    end else if (regWrEn && regIdx < mmr_pkg::IDX_SYS_CONFIG) begin
      for (int j = 0; j < 8; j++) begin
        fixAttr_ff[regIdx * 8 + j][7:5] <= regWrData[j * 8 + 5 +: 3];
        fixAttr_ff[regIdx * 8 + j][2:0] <= regWrData[j * 8 +: 3]; // [R2]
        if (fixModEn) begin
          fixAttr_ff[regIdx * 8 + j][4:3] <= regWrData[j * 8 + 3 +: 2]; // [R4]
        end
      end
    end
  end

  // I/O range pairs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int r = 0; r < mmr_pkg::IO_RANGES; r++) begin
        ioBase_ff[r]  <= '0;
        ioRoute_ff[r] <= 2'b00;
        ioMask_ff[r]  <= '0;
        ioValid_ff[r] <= 1'b0;
      end
    end else if (regWrEn) begin
      for (int r = 0; r < mmr_pkg::IO_RANGES; r++) begin // [R7]
        if (regIdx == mmr_pkg::IDX_IOBASE0 + 8'(2 * r)) begin
          ioBase_ff[r]  <= regWrData[51:12]; // [R9]
          ioRoute_ff[r] <= regWrData[4:3]; // [R8]
        end
        if (regIdx == mmr_pkg::IDX_IOMASK0 + 8'(2 * r)) begin
          ioMask_ff[r]  <= regWrData[51:12]; // [R11]
          ioValid_ff[r] <= regWrData[mmr_pkg::BIT_RANGE_VALID]; // [R10]
        end
      end
    end
  end

  // Memory limits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowLim_ff  <= '0;
      highLim_ff <= '0;
    end else if (regWrEn) begin
      if (regIdx == mmr_pkg::IDX_LOWLIM) begin
        lowLim_ff <= regWrData[51:23]; // [R17]
      end
      if (regIdx == mmr_pkg::IDX_HIGHLIM) begin
        highLim_ff <= regWrData[51:23]; // [R17]
      end
    end
  end

  // Read data select
  always_comb begin
    nxt_rdData = mmr_pkg::RST_WORD;
    nxt_badIdx = 1'b0;
    if (regIdx < mmr_pkg::IDX_SYS_CONFIG) begin
      for (int j = 0; j < 8; j++) begin
        nxt_rdData[j * 8 +: 8] = fixAttr_ff[regIdx * 8 + j];
        if (!fixModEn) begin
          nxt_rdData[j * 8 + 3 +: 2] = 2'b00; // [R4]
        end
      end
    end else if (regIdx == mmr_pkg::IDX_SYS_CONFIG) begin
      nxt_rdData[mmr_pkg::BIT_HIGH_LIM_EN:mmr_pkg::BIT_FIX_ROUTE_EN] = system_configuration_ff;
    end else if (regIdx == mmr_pkg::IDX_IOBASE0 || regIdx == mmr_pkg::IDX_IOBASE1) begin
      nxt_rdData[51:12] = ioBase_ff[regIdx[1]];
      nxt_rdData[4:3]   = ioRoute_ff[regIdx[1]];
    end else if (regIdx == mmr_pkg::IDX_IOMASK0 || regIdx == mmr_pkg::IDX_IOMASK1) begin
      nxt_rdData[51:12] = ioMask_ff[regIdx[1]];
      nxt_rdData[mmr_pkg::BIT_RANGE_VALID] = ioValid_ff[regIdx[1]];
    end else if (regIdx == mmr_pkg::IDX_LOWLIM) begin
      nxt_rdData[51:23] = lowLim_ff;
    end else if (regIdx == mmr_pkg::IDX_HIGHLIM) begin
      nxt_rdData[51:23] = highLim_ff;
    end else begin
      nxt_badIdx = 1'b1;
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData_ff  <= mmr_pkg::RST_WORD;
      regRdValid_ff <= 1'b0;
      regBadIdx_ff  <= 1'b0;
    end else begin
      regRdValid_ff <= regRdEn;
      regBadIdx_ff  <= (regRdEn || regWrEn) && nxt_badIdx;
      if (regRdEn) begin
        regRdData_ff <= nxt_rdData;
      end
    end
  end

  // Routing decision
  always_comb begin
    inFixed = (reqAddr < mmr_pkg::FIX_TOP);
    fixSel  = fixIndex(reqAddr[19:0]);
    fixAttr = fixAttr_ff[fixSel];
    ioHit   = 1'b0;
    ioRoute = 2'b00;
    for (int r = mmr_pkg::IO_RANGES - 1; r >= 0; r--) begin // [R14]
      if (ioValid_ff[r] && rangeMatch(reqAddr[51:12], ioBase_ff[r], ioMask_ff[r])) begin // [R10]
        ioHit   = 1'b1;
        ioRoute = ioRoute_ff[r];
      end
    end
    routeRd     = 1'b0;
    routeWr     = 1'b0;
    nxt_memType = reqVarType;
    checkCombo  = 1'b0;
    if (inFixed) begin
      nxt_memType = fixAttr[mmr_pkg::TYPE_MSB:0]; // [R2]
      checkCombo  = fixRouteEn;
      if (fixRouteEn) begin
        routeRd = fixAttr[mmr_pkg::BIT_READ_FROM_DRAM]; // [R1]
        routeWr = fixAttr[mmr_pkg::BIT_WRITE_TO_DRAM]; // [R1]
      end // [R3]
    end else if (ioHit) begin
      routeRd    = ioRoute[1]; // [R8]
      routeWr    = ioRoute[0]; // [R8]
      checkCombo = 1'b1; // [R13]
    end else if (reqAddr < mmr_pkg::FOUR_GIG) begin
      routeRd    = lowLimEn && (reqAddr[51:23] < lowLim_ff); // [R15] [R18]
      routeWr    = routeRd;
      checkCombo = lowLimEn; // [R19]
    end else begin
      routeRd    = highLimEn && (reqAddr[51:23] < highLim_ff); // [R16] [R18]
      routeWr    = routeRd;
      checkCombo = highLimEn; // [R19]
    end
    nxt_toDram = reqWrite ? routeWr : routeRd;
  end

  mmr_combo_check u_combo (
    .readFromDram (routeRd),
    .writeToDram  (routeWr),
    .memType      (nxt_memType),
    .comboLegal   (comboLegal)
  );

  // Lookup answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rspValid_ff    <= 1'b0;
      rspToDram_ff   <= 1'b0;
      rspMemType_ff  <= mmr_pkg::MT_UC;
      rspComboBad_ff <= 1'b0;
    end else begin
      rspValid_ff <= reqValid;
      if (reqValid) begin
        rspToDram_ff   <= nxt_toDram;
        rspMemType_ff  <= nxt_memType;
        rspComboBad_ff <= checkCombo && !comboLegal; // [R6] [R13] [R19]
      end
    end
  end

  assign regRdData   = regRdData_ff;
  assign regRdValid  = regRdValid_ff;
  assign regBadIdx   = regBadIdx_ff;
  assign rspValid    = rspValid_ff;
  assign rspToDram   = rspToDram_ff;
  assign rspMemType  = rspMemType_ff;
  assign rspComboBad = rspComboBad_ff;

endmodule
`default_nettype wire

// [mmr_router_asserts.sv]
// Checker for mmr_router: answer timing and routing gates.
// Assumes it is bound to mmr_router by the statement at the foot.
`timescale 1ns/100ps
`default_nettype none
module mmr_router_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regIdx,
  input wire logic [63:0] regWrData,
  input wire logic [63:0] regRdData,
  input wire logic        regRdValid,
  input wire logic        regBadIdx,
  // Lookup
  input wire logic        reqValid,
  input wire logic [51:0] reqAddr,
  input wire logic [2:0]  reqVarType,
  input wire logic        rspValid,
  input wire logic        rspToDram,
  input wire logic [2:0]  rspMemType,
  input wire logic        rspComboBad
);
  logic [1:0] cfgGate_ff;
  // Shadow of config bits 19:18
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgGate_ff <= 2'h0;
    end else if (regWrEn && regIdx == mmr_pkg::IDX_SYS_CONFIG) begin
      cfgGate_ff <= regWrData[19:18];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rsp_pulse; rspValid == $past(reqValid); endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer pulse wrong");
  property p_rsp_hold; !rspValid |-> $stable(rspToDram); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("route changed idle");
  property p_fix_off; reqValid && reqAddr < mmr_pkg::FIX_TOP && !cfgGate_ff[0]
    |=> !rspToDram && !rspComboBad; endproperty
  a_fix_off: assert property (p_fix_off) else $error("fixed route while off");
  property p_fix_read; regRdEn && regIdx < mmr_pkg::IDX_SYS_CONFIG && !cfgGate_ff[1]
    |=> (regRdData & 64'h1818_1818_1818_1818) == 64'h0; endproperty
  a_fix_read: assert property (p_fix_read) else $error("route bits visible");
  property p_rd_pulse; regRdEn |=> regRdValid; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer late");
  property p_uc_legal; rspValid && rspMemType == mmr_pkg::MT_UC |-> !rspComboBad; endproperty
  a_uc_legal: assert property (p_uc_legal) else $error("type 0 flagged");
  property p_var_type; reqValid && reqAddr >= mmr_pkg::FIX_TOP
    |=> rspMemType == $past(reqVarType); endproperty
  a_var_type: assert property (p_var_type) else $error("type not passed");
  property p_bad_idx; (regRdEn || regWrEn) && regIdx > mmr_pkg::IDX_HIGHLIM |=> regBadIdx;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("bad index missed");
  c_combo_bad: cover property (rspValid && rspComboBad);
  c_bad_idx: cover property (regBadIdx);
  c_dram: cover property (rspValid && rspToDram);
endmodule
bind mmr_router mmr_router_asserts i_mmr_router_asserts (
  .clk, .sys_rst, .regWrEn, .regRdEn, .regIdx, .regWrData, .regRdData, .regRdValid,
  .regBadIdx, .reqValid, .reqAddr, .reqVarType, .rspValid, .rspToDram, .rspMemType,
  .rspComboBad
);
`default_nettype wire

// [mmr_far_side.sv]
// Far-side model: tallies answers taken by the memory path and the I/O bus.
// Assumes one answer per rspValid pulse.
`timescale 1ns/100ps
`default_nettype none
module mmr_far_side (
  // Clock and reset
  input wire logic   clk,
  input wire logic   sys_rst,
  // Router answer
  input wire logic   rspValid,
  input wire logic   rspToDram,
  // Tallies
  output logic [7:0] dramHits_ff,
  output logic [7:0] ioHits_ff
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dramHits_ff <= 8'h00;
      ioHits_ff <= 8'h00;
    end else if (rspValid) begin
      dramHits_ff <= dramHits_ff + {7'h0, rspToDram};
      ioHits_ff <= ioHits_ff + {7'h0, !rspToDram};
    end
  end
endmodule
`default_nettype wire

// [mmr_router_test.sv]
// Self-checking bench for mmr_router: hand tests, a table of lookups, then more hand tests.
// Assumes the router, far-side model and bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module mmr_router_test;
  typedef struct packed {
    logic [51:0] addr;
    logic        wr;
    logic [2:0]  vt;
    logic        dram;
    logic [2:0]  mt;
    logic        bad;
  } mmr_row_t;
  localparam logic [63:0] MASK4K = 64'h000F_FFFF_FFFF_F800;
  logic        clk, sys_rst, regWrEn, regRdEn, reqValid, reqWrite;
  logic        regRdValid, regBadIdx, rspValid, rspToDram, rspComboBad;
  logic [7:0]  regIdx, dramHits_ff, ioHits_ff;
  logic [63:0] regWrData, regRdData, nDram, nIo;
  logic [51:0] reqAddr;
  logic [2:0]  reqVarType, rspMemType;
  int          errCount, checks;
  mmr_row_t    rows [16] = '{
    '{52'h0, 1'h1, 3'h0, 1'h1, 3'h6, 1'h0},
    '{52'h1_0000, 1'h1, 3'h0, 1'h1, 3'h0, 1'h0},
    '{52'h1_0000, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0},
    '{52'h2_0000, 1'h0, 3'h0, 1'h1, 3'h6, 1'h1},
    '{52'h8_0000, 1'h0, 3'h0, 1'h1, 3'h6, 1'h0},
    '{52'hC_0FFF, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0},
    '{52'hC_1000, 1'h0, 3'h0, 1'h1, 3'h5, 1'h0},
    '{52'h2_0000_0000, 1'h0, 3'h6, 1'h1, 3'h6, 1'h0},
    '{52'h2_0000_0000, 1'h1, 3'h5, 1'h1, 3'h5, 1'h1},
    '{52'h1000_0FFF, 1'h1, 3'h0, 1'h1, 3'h0, 1'h0},
    '{52'h1000_0FFF, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0},
    '{52'h1000_1000, 1'h0, 3'h0, 1'h1, 3'h0, 1'h0},
    '{52'h7F80_0000, 1'h0, 3'h0, 1'h1, 3'h0, 1'h0},
    '{52'h8000_0000, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0},
    '{52'h3_FF80_0000, 1'h1, 3'h0, 1'h1, 3'h0, 1'h0},
    '{52'h4_0000_0000, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0}
  };
  mmr_router i_mmr_router (
    .clk, .sys_rst, .regWrEn, .regRdEn, .regIdx, .regWrData, .regRdData, .regRdValid,
    .regBadIdx, .reqValid, .reqWrite, .reqAddr, .reqVarType, .rspValid, .rspToDram,
    .rspMemType, .rspComboBad
  );
  mmr_far_side i_mmr_far_side (.clk, .sys_rst, .rspValid, .rspToDram, .dramHits_ff, .ioHits_ff);
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic regw(input logic [7:0] idx, input logic [63:0] d);
    @(negedge clk);
    regWrEn = 1'h1;
    regIdx = idx;
    regWrData = d;
    @(negedge clk);
    regWrEn = 1'h0;
  endtask
  task automatic regr(input logic [7:0] idx, input logic [63:0] exp);
    @(negedge clk);
    regRdEn = 1'h1;
    regIdx = idx;
    @(posedge clk);
    #1;
    chk("regRdValid", 64'h1, {63'h0, regRdValid});
    chk("regRdData", exp, regRdData);
    chk("regBadIdx", {63'h0, idx > mmr_pkg::IDX_HIGHLIM}, {63'h0, regBadIdx});
    @(negedge clk);
    regRdEn = 1'h0;
  endtask
  task automatic look(input mmr_row_t r);
    @(negedge clk);
    reqValid = 1'h1;
    reqAddr = r.addr;
    reqWrite = r.wr;
    reqVarType = r.vt;
    @(posedge clk);
    #1;
    chk("rspValid", 64'h1, {63'h0, rspValid});
    chk("rspToDram", {63'h0, r.dram}, {63'h0, rspToDram});
    chk("rspMemType", {61'h0, r.mt}, {61'h0, rspMemType});
    chk("rspComboBad", {63'h0, r.bad}, {63'h0, rspComboBad});
    nDram += {63'h0, r.dram};
    nIo += {63'h0, !r.dram};
    @(negedge clk);
    reqValid = 1'h0;
  endtask
  task automatic finalReport();
    $display("checks %0d, mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    errCount++;
    finalReport();
  end
  initial begin
    sys_rst = 1'h1;
    {regWrEn, regRdEn, reqValid, reqWrite} = 4'h0;
    regIdx = 8'h00;
    {regWrData, nDram, nIo} = '0;
    reqAddr = 52'h0;
    reqVarType = 3'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    regr(mmr_pkg::IDX_SYS_CONFIG, mmr_pkg::RST_WORD);
    regr(mmr_pkg::IDX_IOBASE0, mmr_pkg::RST_WORD);
    $display("reset test done");
    regw(mmr_pkg::IDX_FIX0, 64'h0000_0000_0000_00FF);
    regr(mmr_pkg::IDX_FIX0, 64'h0000_0000_0000_00E7);
    regw(mmr_pkg::IDX_SYS_CONFIG, 64'h0000_0000_0008_0000);
    regw(mmr_pkg::IDX_FIX0, 64'h0000_0000_0016_081E);
    regr(mmr_pkg::IDX_FIX0, 64'h0000_0000_0016_081E);
    look('{52'h0, 1'h1, 3'h0, 1'h0, 3'h6, 1'h0});
    $display("modify gate test done");
    regw(8'h01, 64'h0000_0000_0000_001E);
    regw(8'h03, 64'h0000_0000_0000_1500);
    regw(mmr_pkg::IDX_IOBASE0, 64'h0000_0002_0000_0018);
    regw(mmr_pkg::IDX_IOMASK0, MASK4K);
    regw(mmr_pkg::IDX_IOBASE1, 64'h0000_0000_1000_0008);
    regw(mmr_pkg::IDX_IOMASK1, MASK4K);
    regw(mmr_pkg::IDX_LOWLIM, 64'hFFF0_0000_807F_FFFF);
    regw(mmr_pkg::IDX_HIGHLIM, 64'h0000_0004_0000_0000);
    regr(mmr_pkg::IDX_IOBASE0, 64'h0000_0002_0000_0018);
    regw(mmr_pkg::IDX_SYS_CONFIG, 64'h0000_0000_003C_0000);
    foreach (rows[i]) look(rows[i]);
    $display("table test done");
    regw(mmr_pkg::IDX_IOMASK1, 64'h0);
    look('{52'h1000_0000, 1'h0, 3'h0, 1'h1, 3'h0, 1'h0});
    regw(mmr_pkg::IDX_SYS_CONFIG, 64'h0000_0000_000C_0000);
    look('{52'h1000_0000, 1'h0, 3'h0, 1'h0, 3'h0, 1'h0});
    look('{52'h4_0000_0000, 1'h1, 3'h0, 1'h0, 3'h0, 1'h0});
    $display("limit disable test done");
    regw(mmr_pkg::IDX_SYS_CONFIG, 64'h0000_0000_0004_0000);
    regw(mmr_pkg::IDX_FIX0, 64'h0);
    regr(mmr_pkg::IDX_FIX0, 64'h0);
    look('{52'h0, 1'h1, 3'h0, 1'h1, 3'h0, 1'h0});
    $display("modify lock test done");
    regw(8'h12, 64'hFFFF_FFFF_FFFF_FFFF);
    chk("regBadIdx", 64'h1, {63'h0, regBadIdx});
    regr(8'h12, 64'h0);
    chk("dramHits", nDram, {56'h0, dramHits_ff});
    chk("ioHits", nIo, {56'h0, ioHits_ff});
    $display("bad index test done");
    finalReport();
  end
endmodule
`default_nettype wire
